// *** hw/psram_latency_burst_config.sv ***
// device-side link logic: configuration word, latency signalling and burst sequencing
`include "psram_defs.svh"

module psram_latency_burst_config import psram_pkg::*; #(
   parameter int AW = 8,
   parameter int MEM_WORDS = 256,
   parameter int EXIT_CYC = `DEEP_SLEEP_EXIT_CYC
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic link_clk,
   input wire logic cs_n,
   input wire logic [7:0] dq_in,
   input wire logic read_write_strobe_mask_in,
   output logic [7:0] dq_out,
   output logic dq_oe,
   output logic read_write_strobe_mask_out,
   output logic read_write_strobe_mask_oe,
   output logic [2:0] drive_strength,
   output logic deep_sleep,
   output logic standby
);

   // ********************************
   // core clock domain
   // ********************************
   logic [15:0] cfg_q, wr_word_q, ref_cnt_q;
   logic [2:0] tog_sync_q, drv_q;
   logic new_wr, wr_tog_q, busy_q, sleep_q, standby_q;
   pwr_state_e pwr_q;
   logic [31:0] exit_cnt_q;

   // the written word is held still by the link side until the toggle has crossed
   always_ff @(posedge mclk) begin
      tog_sync_q <= {tog_sync_q[1:0], wr_tog_q};
   end
   assign new_wr = tog_sync_q[2] ^ tog_sync_q[1];

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         cfg_q <= `CFG_RESET; // [R3] [R10] [R17] [R18]
      end else if (new_wr) begin
         cfg_q <= wr_word_q & `CFG_WMASK;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         pwr_q <= PWR_AWAKE; // [R2]
         exit_cnt_q <= 32'h0;
      end else begin
         case (pwr_q)
            PWR_AWAKE: begin
               if (new_wr && !wr_word_q[`CFG_SLEEP_BIT]) begin
                  pwr_q <= PWR_SLEEP; // [R1]
               end
            end
            PWR_SLEEP: begin
               if (new_wr && wr_word_q[`CFG_SLEEP_BIT]) begin
                  pwr_q <= PWR_WAKING; // [R2]
                  exit_cnt_q <= 32'(EXIT_CYC);
               end
            end
            PWR_WAKING: begin
               if (new_wr && !wr_word_q[`CFG_SLEEP_BIT]) begin
                  pwr_q <= PWR_SLEEP; // [R1]
               end else if (exit_cnt_q <= 32'h1) begin
                  pwr_q <= PWR_AWAKE; // [R2]
               end else begin
                  exit_cnt_q <= exit_cnt_q - 32'h1;
               end
            end
            default: pwr_q <= PWR_AWAKE;
         endcase
      end
   end

   // internal housekeeping that, when caught at a transaction start, costs an extra count
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         ref_cnt_q <= 16'h0;
         busy_q <= 1'b0;
      end else begin
         if (ref_cnt_q == `REFRESH_INTERVAL_CYC - 16'h1) begin
            ref_cnt_q <= 16'h0;
         end else begin
            ref_cnt_q <= ref_cnt_q + 16'h1;
         end
         busy_q <= ref_cnt_q < `REFRESH_BUSY_CYC;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         drv_q <= 3'h0;
         sleep_q <= 1'b0;
         standby_q <= 1'b0;
      end else begin
         drv_q <= cfg_q[`CFG_DRV_HI:`CFG_DRV_LO]; // [R3]
         sleep_q <= pwr_q == PWR_SLEEP;
         standby_q <= pwr_q == PWR_AWAKE;
      end
   end
   assign drive_strength = drv_q;
   assign deep_sleep = sleep_q;
   assign standby = standby_q;

   // ********************************
   // crossing into the link domain
   // ********************************
   // the word changes only on register writes, refresh busy edges and power state moves, so waiting for stage two and three
   // to agree keeps a half-moved word from being used
   logic [2:0] rst_sync_q;
   logic [17:0] xs1_q, xs2_q, xs3_q;
   logic [15:0] lcfg_q;
   logic link_rst_n_q, lsleep_q, lbusy_q;

   always_ff @(posedge link_clk) begin
      rst_sync_q <= {rst_sync_q[1:0], nrst};
      if (rst_sync_q[2] == rst_sync_q[1]) begin
         link_rst_n_q <= rst_sync_q[2];
      end
      xs1_q <= {busy_q, sleep_q, cfg_q};
      xs2_q <= xs1_q;
      xs3_q <= xs2_q;
   end

   always_ff @(posedge link_clk) begin
      if (!link_rst_n_q) begin
         lcfg_q <= `CFG_RESET;
         lsleep_q <= 1'b0;
         lbusy_q <= 1'b0;
      end else if (xs2_q == xs3_q) begin
         lcfg_q <= xs3_q[15:0];
         lsleep_q <= xs3_q[16];
         lbusy_q <= xs3_q[17];
      end
   end

   // ********************************
   // link domain
   // ********************************
   function automatic logic [4:0] lat_clocks(input logic [3:0] code);
      logic [4:0] n;
      n = `LAT_RESERVED;
      if (code <= `LAT_CODE_MAX) begin
         n = `LAT_BASE + {1'b0, code}; // [R19]
      end else if (code == `LAT_CODE_3) begin
         n = `LAT_3;
      end else if (code == `LAT_CODE_4) begin
         n = `LAT_4;
      end
      return n; // [R4]
   endfunction

   function automatic logic [31:0] wrap_words(input logic [1:0] code);
      logic [31:0] w;
      case (code)
         `WRAP_128: w = `WORDS_128;
         `WRAP_64: w = `WORDS_64;
         `WRAP_16: w = `WORDS_16;
         default: w = `WORDS_32;
      endcase
      return w; // [R18] [R20]
   endfunction

   link_state_e lst_q;
   logic [2:0] ca_cnt_q;
   logic [39:0] ca_q;
   logic [47:0] ca_full;
   logic [5:0] lat_cnt_q;
   logic [31:0] words_q, addr_q, base_q, cnt_q, next_addr, mask, ca_addr;
   logic dbl_q, rd_q, reg_q, lin_q, hyb_q, phase_q, hi_mask_q, ind;
   logic [7:0] hi_q;
   logic [15:0] mem [MEM_WORDS];
   logic [15:0] rdata, rdata_nx;

   assign ca_full = {ca_q, dq_in};
   assign ca_addr = {ca_full[44:16], ca_full[2:0]};
   assign mask = words_q - 32'h1;
   // strobe level during command/address: fixed mode always asks for two counts
   assign ind = lcfg_q[`CFG_FIX_BIT] ? 1'b1 : lbusy_q; // [R9] [R10] [R11] [R6]

   always_comb begin
      if (lin_q || (hyb_q && cnt_q >= words_q)) begin
         next_addr = addr_q + 32'h1; // [R14]
      end else if (hyb_q && cnt_q == words_q - 32'h1) begin
         next_addr = base_q + words_q; // [R14] [R15]
      end else begin
         next_addr = (addr_q & ~mask) | ((addr_q + 32'h1) & mask); // [R12] [R13] [R16]
      end
   end

   always_comb begin
      if (reg_q) begin
         rdata = (addr_q == `CFG_REG_ADDR) ? lcfg_q : 16'h0;
         rdata_nx = (next_addr == `CFG_REG_ADDR) ? lcfg_q : 16'h0;
      end else begin
         rdata = mem[addr_q[AW-1:0]];
         rdata_nx = mem[next_addr[AW-1:0]];
      end
   end

   // chip select high ends the frame without needing a further link edge
   always_ff @(posedge link_clk or posedge cs_n) begin
      if (cs_n) begin
         lst_q <= LNK_CA;
         ca_cnt_q <= 3'h0;
         ca_q <= 40'h0;
         dbl_q <= 1'b0;
         lat_cnt_q <= 6'h0;
         rd_q <= 1'b0;
         reg_q <= 1'b0;
         lin_q <= 1'b0;
         hyb_q <= 1'b0;
         words_q <= `WORDS_32;
         addr_q <= 32'h0;
         base_q <= 32'h0;
         cnt_q <= 32'h0;
         phase_q <= 1'b0;
         hi_q <= 8'h0;
         hi_mask_q <= 1'b0;
         dq_out <= 8'h0;
         dq_oe <= 1'b0;
         read_write_strobe_mask_out <= 1'b0;
         read_write_strobe_mask_oe <= 1'b0;
      end else if (!link_rst_n_q) begin
         lst_q <= LNK_IGNORE;
         dq_oe <= 1'b0;
         read_write_strobe_mask_oe <= 1'b0;
      end else begin
         case (lst_q)
            LNK_CA: begin
               ca_q <= ca_full[39:0];
               ca_cnt_q <= ca_cnt_q + 3'h1;
               // the sleep flag lags a wake until the crossing catches up, so always drive here
               read_write_strobe_mask_oe <= 1'b1; // [R7]
               read_write_strobe_mask_out <= (ca_cnt_q == 3'h0) ? ind : dbl_q; // [R7]
               if (ca_cnt_q == 3'h0) begin
                  dbl_q <= ind; // [R6]
               end
               if (ca_cnt_q == `CA_LAST_BYTE) begin
                  rd_q <= ca_full[`CA_READ_BIT];
                  reg_q <= ca_full[`CA_REG_BIT];
                  lin_q <= ca_full[`CA_LIN_BIT];
                  hyb_q <= !lcfg_q[`CFG_HYB_BIT]; // [R17]
                  words_q <= wrap_words(lcfg_q[`CFG_WRAP_HI:`CFG_WRAP_LO]);
                  addr_q <= ca_addr;
                  base_q <= ca_addr & ~(wrap_words(lcfg_q[`CFG_WRAP_HI:`CFG_WRAP_LO]) - 32'h1);
                  cnt_q <= 32'h0;
                  phase_q <= 1'b0;
                  if (ca_full[`CA_REG_BIT] && !ca_full[`CA_READ_BIT]) begin
                     // register writes carry no latency; the strobe is released here [R8]
                     lst_q <= LNK_DATA;
                     read_write_strobe_mask_oe <= 1'b0;
                  end else if (lsleep_q) begin
                     lst_q <= LNK_IGNORE;
                     read_write_strobe_mask_oe <= 1'b0;
                  end else begin
                     lst_q <= LNK_LAT; // [R5]
                     lat_cnt_q <= dbl_q ? {lat_clocks(lcfg_q[`CFG_LAT_HI:`CFG_LAT_LO]), 1'b0}
                                        : {1'b0, lat_clocks(lcfg_q[`CFG_LAT_HI:`CFG_LAT_LO])};
                     read_write_strobe_mask_oe <= ca_full[`CA_READ_BIT];
                     read_write_strobe_mask_out <= 1'b0;
                  end
               end
            end
            LNK_LAT: begin
               lat_cnt_q <= lat_cnt_q - 6'h1;
               if (lat_cnt_q == 6'h1) begin
                  lst_q <= LNK_DATA;
                  if (rd_q) begin
                     dq_out <= rdata[15:8];
                     dq_oe <= 1'b1;
                     read_write_strobe_mask_out <= 1'b1;
                  end
               end
            end
            LNK_DATA: begin
               phase_q <= !phase_q;
               if (rd_q) begin
                  if (!phase_q) begin
                     dq_out <= rdata[7:0];
                     read_write_strobe_mask_out <= 1'b0;
                  end else begin
                     dq_out <= rdata_nx[15:8];
                     read_write_strobe_mask_out <= 1'b1;
                  end
               end else if (!phase_q) begin
                  hi_q <= dq_in;
                  hi_mask_q <= read_write_strobe_mask_in;
               end else if (reg_q) begin
                  lst_q <= LNK_IGNORE;
               end
               if (phase_q) begin
                  addr_q <= next_addr;
                  cnt_q <= cnt_q + 32'h1;
               end
            end
            LNK_IGNORE: begin
               dq_oe <= 1'b0;
               read_write_strobe_mask_oe <= 1'b0;
            end
            default: lst_q <= LNK_IGNORE;
         endcase
      end
   end

   // write data: strobe high on a byte masks that byte
   always_ff @(posedge link_clk) begin
      if (lst_q == LNK_DATA && !cs_n && link_rst_n_q && !rd_q && !reg_q && phase_q) begin
         if (!hi_mask_q) begin
            mem[addr_q[AW-1:0]][15:8] <= hi_q;
         end
         if (!read_write_strobe_mask_in) begin
            mem[addr_q[AW-1:0]][7:0] <= dq_in;
         end
      end
   end

   // the word is kept outside the frame reset so it survives until the core takes it
   always_ff @(posedge link_clk) begin
      if (!link_rst_n_q) begin
         wr_word_q <= `CFG_RESET;
         wr_tog_q <= 1'b0;
      end else if (lst_q == LNK_DATA && !cs_n && reg_q && !rd_q && phase_q) begin
         if (addr_q == `CFG_REG_ADDR) begin
            wr_word_q <= {hi_q, dq_in}; // [R1] [R2]
            wr_tog_q <= !wr_tog_q;
         end
      end
   end

endmodule

// *** hw/psram_defs.svh ***
// constants for the pseudo-static memory latency and burst configuration block
// Notes on behaviour
// R1 - a config write clearing bit 15 puts the device into deep sleep at once
// R2 - bit 15 set, or reset, leaves deep sleep; standby follows after the exit time; the logic goes straight to standby on reset, with no exit wait
// R3 - bits 14:12 pick data line output impedance; reset value 000b, the midpoint
// R4 - bits 7:4 set the initial latency, between 3 and 16 clocks
// R5 - memory reads, memory writes and register reads all carry initial latency
// R6 - strobe high during command/address means one extra latency count is inserted
// R7 - strobe always carries the latency indication during command/address
// R8 - controller ignores the strobe indication for zero-latency register writes
// R9 - bit 3 set makes all latency-bearing transactions use one constant latency
// R10 - fixed latency after reset; cleared bit gives variable latency on real need
// R11 - fixed latency holds the strobe high, so every transaction takes two counts; register writes here still take none
// R12 - wrapped bursts stay in an aligned group of 16, 32, 64 or 128 bytes
// R13 - wrapped burst runs from start word to group end, wraps, stops before start; the logic keeps wrapping until chip select rises
// R14 - hybrid burst wraps once then continues linearly until chip select rises
// R15 - hybrid 16 from word 02 gives 02..07, 00, 01, then 08 onward
// R16 - wrap 32 from word 0a gives 0a..0f then 00..09, sixteen words
// R17 - bit 2 picks wrap style: 0 hybrid, 1 legacy wrap (default)
// R18 - bits 1:0 wrap length: 00=128, 01=64, 10=16, 11=32 bytes (default)
// R19 - latency code 0000 is 5 clocks up to 1011 as 16; 1110 is 3, 1111 is 4
// R20 - burst addresses count 16-bit words; a group of N bytes spans N/2 words
`ifndef PSRAM_DEFS_SVH
`define PSRAM_DEFS_SVH
`define CFG_RESET 16'h801f
`define CFG_WMASK 16'hf0ff
`define CFG_REG_ADDR 32'h0000_0800
`define CFG_SLEEP_BIT 15
`define CFG_DRV_HI 14
`define CFG_DRV_LO 12
`define CFG_LAT_HI 7
`define CFG_LAT_LO 4
`define CFG_FIX_BIT 3
`define CFG_HYB_BIT 2
`define CFG_WRAP_HI 1
`define CFG_WRAP_LO 0
`define CA_READ_BIT 47
`define CA_REG_BIT 46
`define CA_LIN_BIT 45
`define CA_LAST_BYTE 3'h5
`define LAT_BASE 5'h05
`define LAT_CODE_MAX 4'hb
`define LAT_CODE_3 4'he
`define LAT_CODE_4 4'hf
`define LAT_3 5'h03
`define LAT_4 5'h04
`define LAT_RESERVED 5'h10
`define WRAP_128 2'h0
`define WRAP_64 2'h1
`define WRAP_16 2'h2
`define WORDS_128 32'h0000_0040
`define WORDS_64 32'h0000_0020
`define WORDS_32 32'h0000_0010
`define WORDS_16 32'h0000_0008
`define MCLK_PERIOD_NS 100
`define DEEP_SLEEP_EXIT_NS 1000
`define DEEP_SLEEP_EXIT_CYC ((`DEEP_SLEEP_EXIT_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define REFRESH_INTERVAL_CYC 16'h0028
`define REFRESH_BUSY_CYC 16'h0004
`endif

// *** hw/psram_pkg.sv ***
// types shared by the latency and burst configuration block
package psram_pkg;
   typedef enum logic [1:0] {PWR_AWAKE, PWR_SLEEP, PWR_WAKING} pwr_state_e;
   typedef enum logic [1:0] {LNK_CA, LNK_LAT, LNK_DATA, LNK_IGNORE} link_state_e;
endpackage

// *** bench/psram_lbc_chk.sv ***
// checker for power state, strobe and read framing at the block's ports
// ****************************************
// assertions
// ****************************************
module psram_lbc_chk #(
   parameter int EXIT_CYC = 10
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic link_clk,
   input wire logic cs_n,
   input wire logic [7:0] dq_in,
   input wire logic read_write_strobe_mask_in,
   input wire logic [7:0] dq_out,
   input wire logic dq_oe,
   input wire logic read_write_strobe_mask_out,
   input wire logic read_write_strobe_mask_oe,
   input wire logic [2:0] drive_strength,
   input wire logic deep_sleep,
   input wire logic standby
);
   logic [7:0] cnt_q;
   logic [7:0] wake_q;
   logic slept_q;
   // edges seen in the current frame; select high clears it at once
   always_ff @(posedge link_clk or posedge cs_n) begin
      if (cs_n) cnt_q <= 8'h00;
      else if (cnt_q != 8'hff) cnt_q <= cnt_q + 8'h01;
   end
   always_ff @(posedge mclk) begin
      if (!nrst || deep_sleep) wake_q <= 8'h00;
      else if (wake_q != 8'hff) wake_q <= wake_q + 8'h01;
   end
   always_ff @(posedge mclk) begin
      if (!nrst) slept_q <= 1'b0;
      else if (deep_sleep) slept_q <= 1'b1;
   end
   a_reset_vals: assert property (@(posedge mclk) disable iff (!nrst)
      $rose(nrst) |-> drive_strength == 3'h0 && !deep_sleep) else $error("reset values wrong");
   a_sleep_quiet: assert property (@(posedge mclk) disable iff (!nrst)
      deep_sleep |-> !standby && !dq_oe) else $error("active while asleep");
   // one cycle of slack: the exit count may start on the write, before the flag drops
   a_wake_delay: assert property (@(posedge mclk) disable iff (!nrst)
      $rose(standby) && slept_q |-> wake_q >= EXIT_CYC - 1) else $error("standby too early");
   a_wake_bound: assert property (@(posedge mclk) disable iff (!nrst)
      $fell(deep_sleep) |-> ##[1:20] standby) else $error("standby never returned");
   a_cs_release: assert property (@(posedge mclk) disable iff (!nrst)
      cs_n |-> !dq_oe && !read_write_strobe_mask_oe) else $error("driving with select high");
   a_ca_strobe: assert property (@(posedge link_clk) disable iff (!nrst)
      standby && cnt_q inside {[8'h01:8'h05]} |-> read_write_strobe_mask_oe) else $error("no strobe in command phase");
   a_ca_steady: assert property (@(posedge link_clk) disable iff (!nrst)
      cnt_q inside {[8'h02:8'h05]} |-> $stable(read_write_strobe_mask_out)) else $error("strobe moved in command phase");
   a_ca_no_data: assert property (@(posedge link_clk) disable iff (!nrst)
      cnt_q < 8'h09 |-> !dq_oe) else $error("data before minimum latency");
   a_byte_pair: assert property (@(posedge link_clk) disable iff (!nrst)
      dq_oe && $past(dq_oe) |-> read_write_strobe_mask_out != $past(read_write_strobe_mask_out)) else $error("strobe did not toggle");
   a_first_hi: assert property (@(posedge link_clk) disable iff (!nrst)
      $rose(dq_oe) |-> read_write_strobe_mask_out) else $error("first byte not high byte");
endmodule

bind psram_latency_burst_config psram_lbc_chk #(.EXIT_CYC(EXIT_CYC)) u_chk (.mclk(mclk), .nrst(nrst),
   .link_clk(link_clk), .cs_n(cs_n), .dq_in(dq_in), .read_write_strobe_mask_in(read_write_strobe_mask_in), .dq_out(dq_out), .dq_oe(dq_oe),
   .read_write_strobe_mask_out(read_write_strobe_mask_out), .read_write_strobe_mask_oe(read_write_strobe_mask_oe), .drive_strength(drive_strength), .deep_sleep(deep_sleep),
   .standby(standby));

// *** bench/psram_ctrl_model.sv ***
// link master model: clock within frames and in idle runs, command bytes, write data
module psram_ctrl_model (
   output logic link_clk,
   output logic cs_n,
   output logic [7:0] dq_in,
   output logic read_write_strobe_mask_in,
   input wire logic [7:0] dq_out,
   input wire logic dq_oe,
   input wire logic read_write_strobe_mask_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic ind;
   logic wd = 1'b0;
   logic [9:0] smp[$];
   initial begin
      link_clk = 1'b0;
      cs_n = 1'b1;
      dq_in = 8'h5a;
      read_write_strobe_mask_in = 1'b0;
   end
   // an undriven mask line toggles so a stale level never reads as valid
   // callers change their lines just after the falling edge, half a period before the next rise
   task automatic tick();
      #7.5;
      link_clk = 1'b1;
      #7.5;
      smp.push_back({dq_oe, read_write_strobe_mask_out, dq_out});
      link_clk = 1'b0;
      if (!wd) read_write_strobe_mask_in = ~read_write_strobe_mask_in;
   endtask
   task automatic idle(input int n);
      repeat (n) tick();
   endtask
   task automatic start(input logic [47:0] ca);
      smp.delete();
      cs_n = 1'b0;
      for (int i = 5; i >= 0; i--) begin
         dq_in = ca[8*i +: 8];
         tick();
      end
      ind = smp[0][8];
      smp.delete();
   endtask
   task automatic stop();
      cs_n = 1'b1;
      dq_in = ~dq_in;
      #30;
   endtask
   task automatic write(input logic [47:0] ca, input int lat, input logic [15:0] w[$]);
      start(ca);
      if (!ca[46]) repeat (ind ? 2 * lat : lat) tick();
      wd = 1'b1;
      read_write_strobe_mask_in = 1'b0;
      foreach (w[i]) begin
         dq_in = w[i][15:8];
         tick();
         dq_in = w[i][7:0];
         tick();
      end
      wd = 1'b0;
      stop();
   endtask
   task automatic read(input logic [47:0] ca, input int n);
      start(ca);
      repeat (n) begin
         dq_in = ~dq_in;
         tick();
      end
      stop();
   endtask
endmodule

// *** bench/psram_latency_burst_config_tb.sv ***
// self-checking bench for the latency and burst configuration block
`include "psram_defs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module psram_latency_burst_config_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk;
   logic nrst;
   logic link_clk;
   logic cs_n;
   logic [7:0] dq_in;
   logic read_write_strobe_mask_in;
   logic [7:0] dq_out;
   logic dq_oe;
   logic read_write_strobe_mask_out;
   logic read_write_strobe_mask_oe;
   logic [2:0] drive_strength;
   logic deep_sleep;
   logic standby;
   int n_mismatch;
   int checks;
   int first;
   int lat;
   int mode;
   logic [31:0] lfsr_q = 32'h3c1f;
   logic [15:0] mem[256];
   logic [15:0] wq[$];
   logic [15:0] tcfg[7] = '{16'h900f, 16'ha0b2, 16'hb0ec, 16'hc0f1, 16'hf058, 16'hd0c6, 16'he03f};
   int tst[7] = '{10, 2, 3, 67, 131, 45, 115};
   int tn[7] = '{16, 12, 64, 36, 68, 8, 20};
   int wtab[4] = '{64, 32, 8, 16};
   psram_latency_burst_config #(.EXIT_CYC(2)) DUT (.mclk(mclk), .nrst(nrst), .link_clk(link_clk), .cs_n(cs_n),
      .dq_in(dq_in), .read_write_strobe_mask_in(read_write_strobe_mask_in), .dq_out(dq_out), .dq_oe(dq_oe), .read_write_strobe_mask_out(read_write_strobe_mask_out), .read_write_strobe_mask_oe(read_write_strobe_mask_oe),
      .drive_strength(drive_strength), .deep_sleep(deep_sleep), .standby(standby));
   psram_ctrl_model ctrl (.link_clk(link_clk), .cs_n(cs_n), .dq_in(dq_in), .read_write_strobe_mask_in(read_write_strobe_mask_in), .dq_out(dq_out),
      .dq_oe(dq_oe), .read_write_strobe_mask_out(read_write_strobe_mask_out));
   always #50 mclk = ~mclk;
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic int lat_of(input logic [3:0] c);
      if (c <= 4'hb) return 5 + c;
      if (c >= 4'he) return c - 11;
      return 16;
   endfunction
   function automatic logic [47:0] mkca(input logic rd, input logic sp, input logic lin, input int a);
      logic [47:0] ca;
      ca = {rd, sp, lin, 45'h0};
      ca[44:16] = 29'(a >> 3);
      ca[2:0] = 3'(a);
      return ca;
   endfunction
   // burst word index k: mode 0 wrap, 1 hybrid, 2 linear
   function automatic int seq(input int s, input int w, input int m, input int k);
      if (m == 2) return (s + k) % 256;
      if (m == 1 && k >= w) return (s - s % w + k) % 256;
      return s - s % w + (s % w + k) % w;
   endfunction
   // ****************************************
   // bus tasks
   // ****************************************
   task automatic wait_mclk(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic do_reset();
      nrst = 1'b0;
      ctrl.idle(8);
      wait_mclk(16);
      nrst = 1'b1;
      ctrl.idle(8);
      wait_mclk(8);
   endtask
   task automatic set_cfg(input logic [15:0] v);
      wq.delete();
      wq.push_back(v);
      ctrl.write(mkca(1'b0, 1'b1, 1'b1, `CFG_REG_ADDR), 0, wq);
      wait_mclk(12);
   endtask
   // first holds the sample index of the first driven byte, -1 if none
   task automatic read_words(input logic [47:0] ca, input int n);
      logic [9:0] s[$];
      ctrl.read(ca, n);
      s = ctrl.smp;
      first = -1;
      wq.delete();
      foreach (s[i]) if (s[i][9]) begin
         if (first < 0) first = i;
         if ((i - first) % 2 == 1) wq.push_back({s[i-1][7:0], s[i][7:0]});
      end
   endtask
   task automatic give_verdict();
      $display("mismatches %0d, checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      mclk = 1'b0;
      n_mismatch = 0;
      checks = 0;
      do_reset();
      `CHK(standby, 1'b1)
      `CHK(drive_strength, 3'h0)
      wq.delete();
      for (int i = 0; i < 256; i++) begin
         lfsr_q = lfsr(lfsr_q);
         mem[i] = lfsr_q[15:0];
         wq.push_back(mem[i]);
      end
      ctrl.write(mkca(1'b0, 1'b0, 1'b1, 0), lat_of(4'h1), wq);
      `CHK(ctrl.ind, 1'b1)
      read_words(mkca(1'b1, 1'b1, 1'b1, `CFG_REG_ADDR), 40);
      `CHK(wq[0], `CFG_RESET)
      `CHK(first, 2 * lat_of(4'h1) - 1)
      foreach (tcfg[t]) begin
         set_cfg(tcfg[t]);
         `CHK(drive_strength, tcfg[t][14:12])
         read_words(mkca(1'b1, 1'b1, 1'b1, `CFG_REG_ADDR), 80);
         `CHK(wq[0], tcfg[t] & `CFG_WMASK)
         lat = lat_of(tcfg[t][7:4]);
         mode = (t == 6) ? 2 : (tcfg[t][2] ? 0 : 1);
         read_words(mkca(1'b1, 1'b0, t == 6, tst[t]), 4 * lat + 2 * tn[t] + 2);
         if (tcfg[t][3]) `CHK(ctrl.ind, 1'b1)
         `CHK(first, (ctrl.ind ? 2 : 1) * lat - 1)
         for (int k = 0; k < tn[t]; k++) `CHK(wq[k], mem[seq(tst[t], wtab[tcfg[t][1:0]], mode, k)])
      end
      // hybrid 16 from word 02 and wrap 32 from word 0a sit in the table above
      set_cfg(16'h001f);
      `CHK(deep_sleep, 1'b1)
      `CHK(standby, 1'b0)
      read_words(mkca(1'b1, 1'b0, 1'b1, 0), 60);
      `CHK(first, -1)
      set_cfg(`CFG_RESET);
      `CHK(deep_sleep, 1'b0)
      `CHK(standby, 1'b1)
      set_cfg(16'h001f);
      do_reset();
      `CHK(deep_sleep, 1'b0)
      read_words(mkca(1'b1, 1'b1, 1'b1, `CFG_REG_ADDR), 40);
      `CHK(wq[0], `CFG_RESET)
      give_verdict();
   end
   initial begin
      #1000000;
      n_mismatch++;
      give_verdict();
   end
endmodule
